/* hdl/sfg_defines.svh */
// constants for the speculative fetch guard
// assumes byte addresses of 32 bits and one instruction word per fetch request
`ifndef SFG_DEFINES_SVH
`define SFG_DEFINES_SVH

// words that may be fetched past an unresolved conditional branch
`define SFG_SPEC_DEPTH 3'h5
// region guard after reset: every 128MB region guarded
`define SFG_RG_RESET 32'hFFFF_FFFF
// address bits that pick the 128MB region
`define SFG_REGION_MSB 31
`define SFG_REGION_LSB 27
// byte step between sequential fetch words
`define SFG_WORD_STEP 32'h0000_0004

`endif

/* hdl/sfg_pkg.sv */
// types shared by the speculative fetch guard files
// assumes nothing beyond the defines header
`default_nettype none

package sfg_pkg;
    typedef logic [31:0] sfg_addr_type;
    typedef logic [4:0] sfg_region_type;
    // gray along run -> spec -> run
    typedef enum logic [1:0] {
        SFG_RUN = 2'b00,
        SFG_SPEC = 2'b01
    } sfg_state_type;
endpackage

`default_nettype wire

/* hdl/sfg_guard_lookup.sv */
// guard lookup for one fetch address
// assumes the page guarded bit comes from the translation buffer for the same address
`default_nettype none
`include "sfg_defines.svh"

module sfg_guard_lookup (
    // address under test
    input wire logic [31:0] addr,
    // translation state
    input wire logic xlate_en,
    input wire logic tlb_guarded,
    input wire logic [31:0] region_guard,
    // result
    output logic guarded
);
    wire sfg_pkg::sfg_region_type region_idx;
    wire logic region_bit;

    // top five bits index the region guard, bit 15 is 0x7800_0000 up
    assign region_idx = addr[`SFG_REGION_MSB:`SFG_REGION_LSB];
    assign region_bit = region_guard[region_idx];
    // page attribute rules while translating, region bits otherwise
    assign guarded = xlate_en ? tlb_guarded : region_bit;
endmodule

`default_nettype wire

/* hdl/sfg_fetch_guard.sv */
// speculative fetch control between the decode stage and the instruction cache unit
// assumes decode and execute events are single-cycle pulses synchronous to ref_clk
`default_nettype none
`include "sfg_defines.svh"

module sfg_fetch_guard (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // guard configuration
    input wire logic xlate_en,
    input wire logic tlb_guarded,
    input wire logic rg_wr_en,
    input wire logic [31:0] rg_wr_data,
    // decode stage
    input wire logic dcd_valid,
    input wire logic dcd_uncond_branch,
    input wire logic dcd_cond_unresolved,
    input wire logic dcd_pred_taken,
    input wire logic [31:0] dcd_target,
    input wire logic dcd_ctr_branch,
    input wire logic dcd_lr_branch,
    input wire logic dcd_trap_word_instr,
    // execute stage
    input wire logic ctr_move_busy,
    input wire logic lr_move_busy,
    input wire logic [31:0] count_register,
    input wire logic [31:0] link_register,
    input wire logic branch_resolved,
    input wire logic redirect_valid,
    input wire logic [31:0] redirect_addr,
    input wire logic exec_valid,
    input wire logic [31:0] exec_addr,
    // instruction cache unit
    input wire logic icu_ready,
    input wire logic icu_mchk,
    input wire logic [31:0] icu_mchk_addr,
    output logic req_valid,
    output logic [31:0] req_addr,
    output logic req_spec,
    // status and exception
    output logic fetch_held,
    output logic mchk_exc
);
    sfg_pkg::sfg_state_type state_q, state_d;
    logic [31:0] region_guard_q;
    logic [31:0] pc_q, pc_d;
    logic [2:0] spec_cnt_q;
    logic trap_block_q;
    logic ind_wait_q, ind_wait_d;
    logic ind_is_ctr_q, ind_is_ctr_d;
    logic req_valid_q, req_spec_q, fetch_held_q, mchk_exc_q;
    logic [31:0] req_addr_q;
    logic err_pend_q;
    logic [31:0] err_addr_q;

    wire logic dcd_indirect;
    wire logic ind_now;
    wire logic ind_ctr;
    wire logic move_busy;
    wire logic stall_ind;
    wire logic [31:0] reg_target;
    wire logic dcd_redirect;
    wire logic [31:0] cand;
    wire logic guarded;
    wire logic spec;
    wire logic depth_full;
    wire logic load_slot;
    wire logic issue_ok;
    wire logic fire;
    wire logic mchk_hit;

    // sys call and interrupt return have no input here: they are ordinary flow
    assign dcd_indirect = dcd_valid & (dcd_ctr_branch | dcd_lr_branch) & dcd_pred_taken;
    assign ind_now = dcd_indirect | ind_wait_q;
    assign ind_ctr = dcd_indirect ? dcd_ctr_branch : ind_is_ctr_q;
    assign move_busy = ind_ctr ? ctr_move_busy : lr_move_busy;
    // stale register is only avoided when a move is in flight or a trap replaced it
    assign stall_ind = ind_now & (move_busy | trap_block_q);
    // count value used as is, even if stale, when no move is in flight and no trap stands
    assign reg_target = ind_ctr ? count_register : link_register;
    // unconditional targets taken as safe; predicted-taken conditional targets stay speculative
    assign dcd_redirect = dcd_valid & (dcd_uncond_branch | (dcd_cond_unresolved & dcd_pred_taken));
    assign cand = redirect_valid ? redirect_addr :
                  (ind_now & ~stall_ind) ? reg_target :
                  dcd_redirect ? dcd_target : pc_q;
    assign spec = (state_q == sfg_pkg::SFG_SPEC) | (dcd_valid & dcd_cond_unresolved);
    assign depth_full = (state_q == sfg_pkg::SFG_SPEC) & (spec_cnt_q >= `SFG_SPEC_DEPTH);
    assign load_slot = ~req_valid_q | icu_ready;
    // guarded space is fetched only once the path is resolved
    assign issue_ok = redirect_valid |
                      (~(ind_now & stall_ind) & ~(spec & (guarded | depth_full)));
    assign fire = clk_en & load_slot & issue_ok;
    assign mchk_hit = exec_valid & err_pend_q & (exec_addr == err_addr_q);

    sfg_guard_lookup u_lookup (
        .addr(cand),
        .xlate_en(xlate_en),
        .tlb_guarded(tlb_guarded),
        .region_guard(region_guard_q),
        .guarded(guarded)
    );

    // next sequential pc keeps redirects even while the request slot is busy
    always_comb begin
        pc_d = pc_q;
        if (fire) begin
            pc_d = cand + `SFG_WORD_STEP;
        end else if (redirect_valid | (ind_now & ~stall_ind) | dcd_redirect) begin
            pc_d = cand;
        end
    end

    // an indirect branch waiting on its register stays remembered
    always_comb begin
        ind_wait_d = ind_wait_q;
        ind_is_ctr_d = ind_is_ctr_q;
        if (redirect_valid | (ind_now & ~stall_ind)) begin
            ind_wait_d = 1'b0;
        end else if (dcd_indirect) begin
            ind_wait_d = 1'b1;
            ind_is_ctr_d = dcd_ctr_branch;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            sfg_pkg::SFG_RUN: begin
                if (dcd_valid & dcd_cond_unresolved & ~redirect_valid) begin
                    state_d = sfg_pkg::SFG_SPEC;
                end
            end
            sfg_pkg::SFG_SPEC: begin
                if (branch_resolved | redirect_valid) begin
                    state_d = sfg_pkg::SFG_RUN;
                end
            end
            default: state_d = sfg_pkg::SFG_RUN;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            region_guard_q <= `SFG_RG_RESET;
        end else if (clk_en & rg_wr_en) begin
            region_guard_q <= rg_wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= sfg_pkg::SFG_RUN;
            pc_q <= 32'h0000_0000;
            ind_wait_q <= 1'b0;
            ind_is_ctr_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            pc_q <= pc_d;
            ind_wait_q <= ind_wait_d;
            ind_is_ctr_q <= ind_is_ctr_d;
        end
    end

    // depth counts words issued since the unresolved branch entered decode
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            spec_cnt_q <= 3'h0;
        end else if (clk_en) begin
            if (state_d != sfg_pkg::SFG_SPEC) begin
                spec_cnt_q <= 3'h0;
            end else if (fire & ~redirect_valid) begin
                spec_cnt_q <= spec_cnt_q + 3'h1;
            end
        end
    end

    // trap stands until the pipeline redirects; set wins over the clear
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            trap_block_q <= 1'b0;
        end else if (clk_en) begin
            if (dcd_valid & dcd_trap_word_instr) begin
                trap_block_q <= 1'b1;
            end else if (redirect_valid) begin
                trap_block_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            req_valid_q <= 1'b0;
            req_addr_q <= 32'h0000_0000;
            req_spec_q <= 1'b0;
            fetch_held_q <= 1'b0;
        end else if (clk_en) begin
            fetch_held_q <= load_slot & ~issue_ok;
            if (load_slot) begin
                req_valid_q <= issue_ok;
                req_addr_q <= cand;
                req_spec_q <= spec & ~redirect_valid;
            end
        end
    end

    // error is parked; it becomes an exception only when execution reaches it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            err_pend_q <= 1'b0;
            err_addr_q <= 32'h0000_0000;
            mchk_exc_q <= 1'b0;
        end else if (clk_en) begin
            mchk_exc_q <= mchk_hit;
            if (icu_mchk) begin
                err_pend_q <= 1'b1;
                err_addr_q <= icu_mchk_addr;
            end else if (mchk_hit) begin
                err_pend_q <= 1'b0;
            end
        end
    end

    assign req_valid = req_valid_q;
    assign req_addr = req_addr_q;
    assign req_spec = req_spec_q;
    assign fetch_held = fetch_held_q;
    assign mchk_exc = mchk_exc_q;

    spec_depth_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        spec_cnt_q <= 3'h5)
        else $error("speculative depth passed five words");
    guard_reset_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (region_guard_q != 32'hFFFF_FFFF)
        |-> (($past(rg_wr_en) && $past(clk_en)) || $past(region_guard_q) != 32'hFFFF_FFFF))
        else $error("region guard left all-guarded without a write");
    region_sel_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!xlate_en && cand[31:27] == 5'd15) |-> (guarded == region_guard_q[15]))
        else $error("region bit 15 not used for 0x7800_0000 region");
    guard_spec_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && load_slot && spec && guarded && !redirect_valid) |=> !req_valid_q)
        else $error("speculative fetch issued into guarded storage");
    uncond_target_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (fire && dcd_valid && dcd_uncond_branch && !redirect_valid && !ind_now)
        |=> (req_valid_q && req_addr_q == $past(dcd_target)))
        else $error("unconditional branch did not redirect fetch");
    ctr_target_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (fire && ind_now && ind_ctr && !stall_ind && !redirect_valid)
        |=> (req_addr_q == $past(count_register)))
        else $error("count branch not fetched from count value");
    move_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && load_slot && stall_ind && !redirect_valid) |=> !req_valid_q)
        else $error("fetch issued while register move in flight");
    trap_block_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && dcd_valid && dcd_trap_word_instr) |=> trap_block_q)
        else $error("trap did not block indirect fetch");
    mchk_defer_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (mchk_exc_q && $past(clk_en)) |-> $past(mchk_hit))
        else $error("machine check raised before execution reached it");
endmodule

`default_nettype wire

/* sim/sfg_icu_model.sv */
// instruction cache unit model on the far side of the fetch guard
// assumes requests hold until icu_ready, one word per request
`default_nettype none

module sfg_icu_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // fetch request
    input wire logic req_valid,
    input wire logic [31:0] req_addr,
    output logic icu_ready,
    output logic icu_mchk,
    output logic [31:0] icu_mchk_addr,
    // scenario control
    input wire logic slow,
    input wire logic [31:0] bad_addr
);
    timeunit 1ns;
    timeprecision 1ps;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            icu_ready <= 1'b0;
            icu_mchk <= 1'b0;
            icu_mchk_addr <= 32'h0000_0000;
        end else begin
            // slow answers every other cycle
            icu_ready <= !slow || !icu_ready;
            icu_mchk <= req_valid && icu_ready && req_addr == bad_addr;
            // flips between errors so a stale address never looks valid
            icu_mchk_addr <= (req_valid && icu_ready) ? req_addr : ~icu_mchk_addr;
        end
    end
endmodule

`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the speculative fetch guard
// assumes the icu model answers and the bench plays decode and execute
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic xlate_en = 1'b0, tlb_guarded = 1'b0, rg_wr_en = 1'b0, dcd_valid = 1'b0;
    logic dcd_uncond_branch = 1'b0, dcd_cond_unresolved = 1'b0, dcd_pred_taken = 1'b0;
    logic dcd_ctr_branch = 1'b0, dcd_lr_branch = 1'b0, dcd_trap_word_instr = 1'b0;
    logic ctr_move_busy = 1'b0, branch_resolved = 1'b0, redirect_valid = 1'b0;
    logic exec_valid = 1'b0, slow = 1'b0, clk_en = 1'b1;
    logic [31:0] rg_wr_data = 32'h0000_0000, dcd_target = 32'h0000_0000;
    logic [31:0] count_register = 32'h0000_0000, redirect_addr = 32'h0000_0000;
    logic [31:0] exec_addr = 32'h0000_0000, bad_addr = 32'hFFFF_FFFC;
    logic icu_ready, icu_mchk, req_valid, req_spec, fetch_held, mchk_exc;
    logic [31:0] icu_mchk_addr, req_addr;
    int error_cnt = 0;
    int checked = 0;

    always #2 ref_clk = ~ref_clk;

    sfg_fetch_guard dut (
        .ref_clk, .resetn, .clk_en, .xlate_en, .tlb_guarded, .rg_wr_en,
        .rg_wr_data, .dcd_valid, .dcd_uncond_branch, .dcd_cond_unresolved,
        .dcd_pred_taken, .dcd_target, .dcd_ctr_branch, .dcd_lr_branch,
        .dcd_trap_word_instr, .ctr_move_busy, .lr_move_busy(1'b0), .count_register,
        .link_register(32'h0000_0000), .branch_resolved, .redirect_valid,
        .redirect_addr, .exec_valid, .exec_addr, .icu_ready, .icu_mchk,
        .icu_mchk_addr, .req_valid, .req_addr, .req_spec, .fetch_held, .mchk_exc
    );

    sfg_icu_model icu (
        .ref_clk, .resetn, .req_valid, .req_addr, .icu_ready, .icu_mchk,
        .icu_mchk_addr, .slow, .bad_addr
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // waits for the next accepted request, bounded
    task automatic next_req(input logic [31:0] exp, input logic spec);
        int n;
        n = 0;
        @(posedge ref_clk);
        while (!(req_valid === 1'b1 && icu_ready === 1'b1) && n < 20) begin
            n++;
            @(posedge ref_clk);
        end
        check(req_addr, exp);
        check({31'h0, req_spec}, {31'h0, spec});
    endtask

    task automatic dec(input logic u, c, p, cb, lb, tr, input logic [31:0] t);
        dcd_valid <= 1'b1;
        dcd_uncond_branch <= u;
        dcd_cond_unresolved <= c;
        dcd_pred_taken <= p;
        dcd_ctr_branch <= cb;
        dcd_lr_branch <= lb;
        dcd_trap_word_instr <= tr;
        dcd_target <= t;
        @(posedge ref_clk);
        dcd_valid <= 1'b0;
    endtask

    task automatic redir(input logic [31:0] a);
        redirect_valid <= 1'b1;
        redirect_addr <= a;
        @(posedge ref_clk);
        redirect_valid <= 1'b0;
    endtask

    task automatic resolve();
        branch_resolved <= 1'b1;
        @(posedge ref_clk);
        branch_resolved <= 1'b0;
    endtask

    // not-taken branch at a, then counts speculative words accepted
    task automatic spec_run(input logic wr, xl, tg, input logic [31:0] rg, a, input int exp);
        int acc;
        acc = 0;
        rg_wr_en <= wr;
        rg_wr_data <= rg;
        xlate_en <= xl;
        tlb_guarded <= tg;
        @(posedge ref_clk);
        rg_wr_en <= 1'b0;
        redir(a);
        dec(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, a);
        repeat (12) begin
            @(posedge ref_clk);
            if (req_valid === 1'b1 && icu_ready === 1'b1 && req_spec === 1'b1)
                acc++;
        end
        check(acc, exp);
        check({30'h0, req_valid, fetch_held}, 32'h0000_0001);
        // once resolved the blocked word goes out as a plain fetch
        resolve();
        next_req(a + 32'(4 * exp + 4), 1'b0);
        $display("spec run at %h done", a);
    endtask

    task automatic t_uncond();
        redir(32'h0000_2000);
        dec(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0000_3000);
        next_req(32'h0000_3000, 1'b0);
        next_req(32'h0000_3004, 1'b0);
        slow <= 1'b1;
        next_req(32'h0000_3008, 1'b0);
        next_req(32'h0000_300C, 1'b0);
        slow <= 1'b0;
        redir(32'h0000_4000);
        dec(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_5000);
        next_req(32'h0000_5000, 1'b1);
        resolve();
        $display("branch test done");
    endtask

    task automatic t_indirect();
        count_register <= 32'h0000_6000;
        ctr_move_busy <= 1'b1;
        dec(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 32'h0000_0000);
        repeat (4) @(posedge ref_clk);
        check({30'h0, req_valid, fetch_held}, 32'h0000_0001);
        ctr_move_busy <= 1'b0;
        next_req(32'h0000_6000, 1'b0);
        dec(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 32'h0000_0000);
        @(posedge ref_clk);
        dec(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 32'h0000_0000);
        repeat (4) @(posedge ref_clk);
        check({31'h0, req_valid}, 32'h0000_0000);
        redir(32'h0000_7000);
        next_req(32'h0000_7000, 1'b0);
        // a plain decode, as a system call looks here, keeps the stream
        dec(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
        next_req(32'h0000_7008, 1'b0);
        // branch-to-self right after the return keeps fetch off the stale count target
        dec(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0000_7008);
        next_req(32'h0000_7008, 1'b0);
        $display("indirect test done");
    endtask

    task automatic t_mchk();
        int hits;
        bad_addr <= 32'h0000_8000;
        redir(32'h0000_8000);
        for (int k = 0; k < 3; k++) begin
            exec_valid <= (k > 0);
            exec_addr <= (k == 2) ? 32'h0000_8000 : 32'h0000_8004;
            @(posedge ref_clk);
            exec_valid <= 1'b0;
            hits = 0;
            repeat (4) begin
                @(posedge ref_clk);
                if (mchk_exc === 1'b1)
                    hits++;
            end
            check(hits, (k == 2));
        end
        $display("machine check test done");
    endtask

    // low enable holds the request; a later reset guards everything again
    task automatic t_reset_freeze();
        rg_wr_en <= 1'b1;
        rg_wr_data <= 32'h0000_0000;
        redir(32'h0000_9000);
        rg_wr_en <= 1'b0;
        clk_en <= 1'b0;
        repeat (3) @(posedge ref_clk);
        clk_en <= 1'b1;
        next_req(32'h0000_9000, 1'b0);
        next_req(32'h0000_9004, 1'b0);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        next_req(32'h0000_0000, 1'b0);
        spec_run(1'b0, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_1000, 0);
        $display("freeze and reset test done");
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        next_req(32'h0000_0000, 1'b0);
        spec_run(1'b0, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_1000, 0);
        spec_run(1'b1, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_1000, 5);
        spec_run(1'b1, 1'b0, 1'b0, 32'h0000_8000, 32'h77FF_FFF0, 3);
        spec_run(1'b1, 1'b0, 1'b0, 32'h0000_4000, 32'h77FF_FFF0, 0);
        spec_run(1'b1, 1'b1, 1'b1, 32'h0000_0000, 32'h0000_1000, 0);
        spec_run(1'b1, 1'b1, 1'b0, 32'hFFFF_FFFF, 32'h0000_1000, 5);
        t_uncond();
        t_indirect();
        t_mchk();
        t_reset_freeze();
        give_verdict();
    end

    // tests need well under a thousand cycles
    initial begin
        #20000;
        error_cnt++;
        give_verdict();
    end
endmodule

`default_nettype wire
